// >>> verilog/banked_regs.svh
`ifndef BANKED_REGS_SVH
`define BANKED_REGS_SVH
// Mode field encodings
`define MODE_USR 5'h10
`define MODE_FIQ 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1B
`define MODE_SYS 5'h1F
// Register numbers
`define REG_FIQ_FIRST 4'h8
`define REG_SP 4'hD
`define REG_LR 4'hE
`define REG_PC 4'hF
`define REG_LOW_TOP 4'h7
// Status word layout
`define SW_MODE_LSB 0
`define SW_MODE_MSB 4
`define SW_TBIT 5
`define SW_RESET 32'h000000D3
// Program counter alignment masks, reset value and step sizes
`define PC_MASK_WIDE 32'hFFFFFFFC
`define PC_MASK_NARROW 32'hFFFFFFFE
`define PC_RESET 32'h00000000
`define PC_STEP_WIDE 32'h00000004
`define PC_STEP_NARROW 32'h00000002
`endif

// >>> verilog/banked_pkg.sv
package banked_pkg;
  typedef enum logic [2:0] {
    BANK_USR, BANK_FIQ, BANK_IRQ, BANK_SVC, BANK_ABT, BANK_UND
  } bank_t;
  typedef enum logic [1:0] {
    REQ_NONE, REQ_DATA_ABORT, REQ_PREFETCH_ABORT, REQ_UNDEF
  } exc_t;
endpackage : banked_pkg

// >>> verilog/banked_mode_register_file.sv
`timescale 1ns/1ns
`include "banked_regs.svh"
module banked_mode_register_file #(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Read ports
  input wire logic [3:0] rd_a_idx,
  output logic [DATA_W-1:0] rd_a_data,
  input wire logic [3:0] rd_b_idx,
  output logic [DATA_W-1:0] rd_b_data,
  // High register access allowed in narrow state
  input wire logic hi_access,
  // Write port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  // Program counter update
  input wire logic pc_wr_en,
  input wire logic [DATA_W-1:0] pc_wr_data,
  // Branch-and-link
  input wire logic branch_and_link,
  // Status word writes
  input wire logic cur_sw_wr_en,
  input wire logic [DATA_W-1:0] cur_sw_wr_data,
  input wire logic saved_sw_wr_en,
  input wire logic [DATA_W-1:0] saved_sw_wr_data,
  // Exceptions
  input wire banked_pkg::exc_t exc_req,
  input wire logic [DATA_W-1:0] exc_return,
  // Status outputs
  output logic [DATA_W-1:0] current_status_word,
  output logic [DATA_W-1:0] saved_status_word,
  output logic [DATA_W-1:0] pc_out,
  output logic privileged,
  output logic narrow_state,
  output logic illegal_access
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] shared_q [0:14];
  logic [DATA_W-1:0] fiq_q [8:14];
  logic [DATA_W-1:0] sp_q [2:5];
  logic [DATA_W-1:0] lr_q [2:5];
  logic [DATA_W-1:0] pc_q;
  logic [DATA_W-1:0] current_status_word_q;
  logic [DATA_W-1:0] saved_status_word_q [1:5];

  logic [4:0] mode;
  banked_pkg::bank_t bank;
  banked_pkg::bank_t ex_bank;
  logic [4:0] ex_mode;
  logic mode_ok;
  logic [4:0] new_mode;
  logic sys_ok;

  assign mode = current_status_word_q[`SW_MODE_MSB:`SW_MODE_LSB];
  assign narrow_state = current_status_word_q[`SW_TBIT];

  // ------------------------------------------------------------
  // Bank selection
  // ------------------------------------------------------------
  // mode decode
  always_comb begin
    mode_ok = 1'b1;
    if (mode == `MODE_FIQ) begin
      bank = banked_pkg::BANK_FIQ;
    end else if (mode == `MODE_IRQ) begin
      bank = banked_pkg::BANK_IRQ;
    end else if (mode == `MODE_SVC) begin
      bank = banked_pkg::BANK_SVC;
    end else if (mode == `MODE_ABT) begin
      bank = banked_pkg::BANK_ABT;
    end else if (mode == `MODE_UND) begin
      bank = banked_pkg::BANK_UND;
    end else if (mode == `MODE_USR || mode == `MODE_SYS) begin
      bank = banked_pkg::BANK_USR;
    end else begin
      bank = banked_pkg::BANK_USR;
      mode_ok = 1'b0;
    end
  end

  assign privileged = mode_ok && (mode != `MODE_USR);

  always_comb begin
    case (exc_req)
      banked_pkg::REQ_DATA_ABORT,
      banked_pkg::REQ_PREFETCH_ABORT: begin
        ex_mode = `MODE_ABT;
        ex_bank = banked_pkg::BANK_ABT;
      end
      banked_pkg::REQ_UNDEF: begin
        ex_mode = `MODE_UND;
        ex_bank = banked_pkg::BANK_UND;
      end
      default: begin
        ex_mode = mode;
        ex_bank = bank;
      end
    endcase
  end

  assign new_mode = cur_sw_wr_data[`SW_MODE_MSB:`SW_MODE_LSB];
  assign sys_ok = (new_mode != `MODE_SYS) || privileged;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] read_reg(input logic [3:0] idx);
    logic [DATA_W-1:0] v;
    v = '0;
    if (idx == `REG_PC) begin
      v = pc_q & (narrow_state ? `PC_MASK_NARROW : `PC_MASK_WIDE);
    end else if (bank == banked_pkg::BANK_FIQ && idx >= `REG_FIQ_FIRST) begin
      v = fiq_q[idx];
    end else if (bank != banked_pkg::BANK_USR && idx == `REG_SP) begin
      v = sp_q[bank];
    end else if (bank != banked_pkg::BANK_USR && idx == `REG_LR) begin
      v = lr_q[bank];
    end else begin
      v = shared_q[idx];
    end
    return v;
  endfunction : read_reg

  function automatic logic blocked(input logic [3:0] idx);
    return narrow_state && !hi_access && idx > `REG_LOW_TOP &&
           idx != `REG_SP && idx != `REG_LR && idx != `REG_PC;
  endfunction : blocked

  // shared narrow aliases
  // Process, not assign: the calls read storage that is no argument
  always_comb begin
    rd_a_data = blocked(rd_a_idx) ? '0 : read_reg(rd_a_idx);
    rd_b_data = blocked(rd_b_idx) ? '0 : read_reg(rd_b_idx);
    illegal_access = blocked(rd_a_idx) || blocked(rd_b_idx) ||
                     (wr_en && blocked(wr_idx)) || !mode_ok;
    pc_out = read_reg(`REG_PC);
  end
  assign current_status_word = current_status_word_q;
  assign saved_status_word = (bank == banked_pkg::BANK_USR) ? '0 :
                             saved_status_word_q[bank];

  // ------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------
  logic gpr_we;
  logic bl_we;
  logic [DATA_W-1:0] pc_step;
  always_comb begin
    gpr_we = wr_en && !blocked(wr_idx) && wr_idx != `REG_PC;
  end
  assign bl_we = branch_and_link && exc_req == banked_pkg::REQ_NONE;
  assign pc_step = narrow_state ? `PC_STEP_NARROW : `PC_STEP_WIDE;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 15; i++) shared_q[i] <= '0;
      for (int i = 8; i < 15; i++) fiq_q[i] <= '0;
      for (int i = 2; i < 6; i++) begin
        sp_q[i] <= '0;
        lr_q[i] <= '0;
      end
    end else begin
      if (gpr_we) begin
        if (bank == banked_pkg::BANK_FIQ && wr_idx >= `REG_FIQ_FIRST) begin
          fiq_q[wr_idx] <= wr_data;
        end else if (bank != banked_pkg::BANK_USR && wr_idx == `REG_SP) begin
          sp_q[bank] <= wr_data;
        end else if (bank != banked_pkg::BANK_USR && wr_idx == `REG_LR) begin
          lr_q[bank] <= wr_data;
        end else begin
          shared_q[wr_idx] <= wr_data;
        end
      end
      if (bl_we) begin
        if (bank == banked_pkg::BANK_FIQ) begin
          fiq_q[`REG_LR] <= pc_q + pc_step;
        end else if (bank != banked_pkg::BANK_USR) begin
          lr_q[bank] <= pc_q + pc_step;
        end else begin
          shared_q[`REG_LR] <= pc_q + pc_step;
        end
      end
      if (exc_req != banked_pkg::REQ_NONE) begin
        lr_q[ex_bank] <= exc_return;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc_q <= `PC_RESET;
    end else if (pc_wr_en) begin
      pc_q <= pc_wr_data;
    end else if (wr_en && wr_idx == `REG_PC) begin
      pc_q <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      current_status_word_q <= `SW_RESET;
    end else if (exc_req != banked_pkg::REQ_NONE) begin
      current_status_word_q[`SW_MODE_MSB:`SW_MODE_LSB] <= ex_mode;
      current_status_word_q[`SW_TBIT] <= 1'b0;
    end else if (cur_sw_wr_en && sys_ok) begin
      current_status_word_q <= cur_sw_wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 1; i < 6; i++) saved_status_word_q[i] <= '0;
    end else if (exc_req != banked_pkg::REQ_NONE) begin
      saved_status_word_q[ex_bank] <= current_status_word_q;
    end else if (saved_sw_wr_en && bank != banked_pkg::BANK_USR) begin
      saved_status_word_q[bank] <= saved_sw_wr_data;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  abort_entry_a: assert property (
    exc_req inside {banked_pkg::REQ_DATA_ABORT,
                    banked_pkg::REQ_PREFETCH_ABORT}
    |=> mode == `MODE_ABT)
    else $error("abort did not enter abort mode");
  undef_entry_a: assert property (
    exc_req == banked_pkg::REQ_UNDEF |=> mode == `MODE_UND)
    else $error("undefined did not enter undefined mode");
  sys_guard_a: assert property (
    mode == `MODE_USR && exc_req == banked_pkg::REQ_NONE |=>
    mode != `MODE_SYS)
    else $error("system mode entered from user");
  priv_flag_a: assert property (
    privileged == (mode inside {`MODE_FIQ, `MODE_IRQ, `MODE_SVC, `MODE_ABT,
                                `MODE_UND, `MODE_SYS}))
    else $error("privilege flag wrong");
  exc_link_a: assert property (
    exc_req == banked_pkg::REQ_UNDEF |=>
    lr_q[banked_pkg::BANK_UND] == $past(exc_return))
    else $error("exception link not written");
  saved_status_word_save_a: assert property (
    exc_req == banked_pkg::REQ_DATA_ABORT |=>
    saved_status_word == $past(current_status_word_q))
    else $error("saved status not captured");
  pc_mask_a: assert property (
    !narrow_state |-> pc_out[1:0] == 2'h0)
    else $error("wide pc low bits not ignored");
  pc_narrow_a: assert property (
    narrow_state |-> pc_out[0] == 1'b0 && pc_out[1] == pc_q[1])
    else $error("narrow pc bit handling wrong");
  user_no_saved_status_word_a: assert property (
    bank == banked_pkg::BANK_USR |-> saved_status_word == '0)
    else $error("saved status visible in user mode");
  // Storage checks look inside the banks, not only at the ports; hi_block_a watches the ports alone
  abt_link_a: assert property (
    exc_req inside {banked_pkg::REQ_DATA_ABORT,
                    banked_pkg::REQ_PREFETCH_ABORT}
    |=> lr_q[banked_pkg::BANK_ABT] == $past(exc_return))
    else $error("abort link not written");
  bl_fiq_a: assert property (
    branch_and_link && exc_req == banked_pkg::REQ_NONE &&
    bank == banked_pkg::BANK_FIQ |=>
    fiq_q[`REG_LR] == $past(pc_q) +
    ($past(narrow_state) ? `PC_STEP_NARROW : `PC_STEP_WIDE))
    else $error("fast bank link copy wrong");
  hi_block_a: assert property (
    narrow_state && !hi_access && rd_a_idx > `REG_LOW_TOP &&
    rd_a_idx < `REG_SP |-> rd_a_data == '0 && illegal_access)
    else $error("high register reached in narrow state");
  svc_bank_a: assert property (
    !wr_en && !branch_and_link |=>
    $stable(lr_q[banked_pkg::BANK_SVC]))
    else $error("banked link changed without a write");
  sys_share_a: assert property (
    mode == `MODE_SYS && rd_a_idx == `REG_SP |->
    rd_a_data == shared_q[`REG_SP])
    else $error("system mode not on user registers");
  irq_bank_a: assert property (
    mode == `MODE_IRQ && rd_a_idx == `REG_SP |->
    rd_a_data == sp_q[banked_pkg::BANK_IRQ])
    else $error("interrupt stack pointer not banked");
  fiq_map_a: assert property (
    mode == `MODE_FIQ && !narrow_state &&
    rd_a_idx == `REG_FIQ_FIRST |->
    rd_a_data == fiq_q[`REG_FIQ_FIRST])
    else $error("fast bank not mapped");

  abort_cov: cover property (exc_req == banked_pkg::REQ_DATA_ABORT);
  hi_cov: cover property (narrow_state && hi_access && rd_a_idx == 4'h8);
  bl_cov: cover property (bl_we && bank == banked_pkg::BANK_FIQ);
  sys_cov: cover property (cur_sw_wr_en && new_mode == `MODE_SYS && sys_ok);

endmodule : banked_mode_register_file

// >>> verification/datapath_model.sv
`timescale 1ns/1ns
module datapath_model (
  // Clock
  input wire logic ref_clk,
  // Read requests
  output logic [3:0] rd_a_idx,
  output logic [3:0] rd_b_idx,
  output logic hi_access,
  // Write requests
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic [31:0] wr_data,
  output logic pc_wr_en,
  output logic [31:0] pc_wr_data,
  output logic branch_and_link,
  output logic cur_sw_wr_en,
  output logic [31:0] cur_sw_wr_data,
  output logic saved_sw_wr_en,
  output logic [31:0] saved_sw_wr_data,
  // Exceptions
  output banked_pkg::exc_t exc_req,
  output logic [31:0] exc_return
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    {rd_a_idx, rd_b_idx, wr_idx} = 12'h000;
    {hi_access, wr_en, pc_wr_en, branch_and_link} = 4'h0;
    {cur_sw_wr_en, saved_sw_wr_en} = 2'h0;
    {wr_data, pc_wr_data, cur_sw_wr_data, saved_sw_wr_data, exc_return} = '0;
    exc_req = banked_pkg::REQ_NONE;
  end

  // ----------------------------------------
  // Requests, one cycle each
  // ----------------------------------------
  // Kinds: 0 gpr, 1 pc, 2 link, 3 status, 4 saved, 5..7 exception
  task automatic op(input int k, input logic [3:0] i, input logic [31:0] d);
    @(negedge ref_clk);
    wr_idx = i;
    {wr_data, pc_wr_data, cur_sw_wr_data, saved_sw_wr_data, exc_return} =
      {5{d}};
    case (k)
      0: wr_en = 1'b1;
      1: pc_wr_en = 1'b1;
      2: branch_and_link = 1'b1;
      3: cur_sw_wr_en = 1'b1;
      4: saved_sw_wr_en = 1'b1;
      default: exc_req = banked_pkg::exc_t'(2'(k - 4));
    endcase
    @(negedge ref_clk);
    {wr_en, pc_wr_en, branch_and_link, cur_sw_wr_en, saved_sw_wr_en} = 5'h00;
    exc_req = banked_pkg::REQ_NONE;
    // Released data lines must not keep looking valid
    {wr_data, pc_wr_data, cur_sw_wr_data, saved_sw_wr_data, exc_return} =
      {5{~d}};
  endtask : op

  task automatic look(input logic [3:0] i, input logic h);
    @(negedge ref_clk);
    rd_a_idx = i;
    rd_b_idx = i;
    hi_access = h;
  endtask : look
endmodule : datapath_model

// >>> verification/banked_mode_register_file_tb.sv
`timescale 1ns/1ns
module banked_mode_register_file_tb;
  logic ref_clk;
  logic resetn;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx;
  logic hi_access, wr_en, pc_wr_en, branch_and_link;
  logic cur_sw_wr_en, saved_sw_wr_en, privileged, narrow_state, illegal_access;
  logic [31:0] wr_data, pc_wr_data, cur_sw_wr_data, saved_sw_wr_data;
  logic [31:0] exc_return, rd_a_data, rd_b_data, current_status_word;
  logic [31:0] saved_status_word, pc_out, v, pcv;
  banked_pkg::exc_t exc_req;
  logic [31:0] mdl [96];
  logic [4:0] modes [7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
  logic [4:0] cur;
  int n_errors = 0;
  int total_checks = 0;

  banked_mode_register_file DUT (.ref_clk, .resetn, .rd_a_idx, .rd_a_data,
    .rd_b_idx, .rd_b_data, .hi_access, .wr_en, .wr_idx, .wr_data, .pc_wr_en,
    .pc_wr_data, .branch_and_link, .cur_sw_wr_en, .cur_sw_wr_data,
    .saved_sw_wr_en, .saved_sw_wr_data, .exc_req, .exc_return,
    .current_status_word, .saved_status_word, .pc_out, .privileged,
    .narrow_state, .illegal_access);
  datapath_model dp (.ref_clk, .rd_a_idx, .rd_b_idx, .hi_access, .wr_en,
    .wr_idx, .wr_data, .pc_wr_en, .pc_wr_data, .branch_and_link,
    .cur_sw_wr_en, .cur_sw_wr_data, .saved_sw_wr_en, .saved_sw_wr_data,
    .exc_req, .exc_return);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Comparison and expectation helpers
  // ----------------------------------------
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_b

  // Physical slot: bank times 16 plus visible number
  function automatic int slot(input logic [4:0] m, input logic [3:0] i);
    int b = 0;
    for (int k = 0; k < 6; k++) begin
      if (modes[k] == m) b = k;
    end
    if (i < 4'h8 || (i < 4'hD && b != 1)) b = 0;
    return b * 16 + int'(i);
  endfunction : slot

  task automatic rdchk(input logic [3:0] i, input logic h,
                       input logic [31:0] e);
    dp.look(i, h);
    #2;
    chk_w(rd_a_data, e);
    chk_w(rd_b_data, e);
  endtask : rdchk

  task automatic set_mode(input int j);
    dp.op(3, 4'h0, 32'h000000C0 | modes[j]);
    cur = modes[j];
  endtask : set_mode

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    void'($urandom(32'h90C8CA6D));
    for (int k = 0; k < 96; k++) begin
      mdl[k] = 32'h00000000;
    end
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    chk_w(current_status_word, 32'h000000D3);
    // Fill every bank, user last; from user only system mode is refused
    for (int j = 5; j >= 0; j--) begin
      set_mode(j);
      chk_b(privileged, j != 0);
      for (int i = 0; i < 15; i++) begin
        v = $urandom;
        dp.op(0, 4'(i), v);
        mdl[slot(cur, 4'(i))] = v;
      end
    end
    dp.op(3, 4'h0, 32'h000000DF);
    chk_w(current_status_word, 32'h000000D0);
    v = $urandom;
    dp.op(7, 4'h0, v);
    cur = 5'h1B;
    mdl[slot(cur, 4'hE)] = v;
    chk_w(current_status_word & 32'h0000001F, 32'h0000001B);
    chk_w(saved_status_word, 32'h000000D0);
    // System first: entered from a privileged mode
    for (int j = 6; j >= 0; j--) begin
      set_mode(j);
      chk_w(current_status_word, 32'h000000C0 | modes[j]);
      for (int i = 0; i < 15; i++) begin
        rdchk(4'(i), 1'b0, mdl[slot(cur, 4'(i))]);
      end
      if (j == 0 || j == 6) chk_w(saved_status_word, 32'h00000000);
    end
    dp.op(5, 4'h0, 32'h00001008);
    chk_w(current_status_word & 32'h0000001F, 32'h00000017);
    dp.op(6, 4'h0, 32'h00002004);
    cur = 5'h17;
    rdchk(4'hE, 1'b0, 32'h00002004);
    chk_w(saved_status_word & 32'h0000001F, 32'h00000017);
    dp.op(4, 4'h0, 32'h600000D2);
    chk_w(saved_status_word, 32'h600000D2);
    pcv = $urandom & 32'hFFFFFFFC;
    dp.op(1, 4'h0, pcv);
    dp.op(2, 4'h0, 32'h00000000);
    rdchk(4'hE, 1'b0, pcv + 32'h00000004);
    dp.op(1, 4'h0, pcv | 32'h00000003);
    chk_w(pc_out, pcv);
    dp.op(3, 4'h0, 32'h000000F3);
    chk_b(narrow_state, 1'b1);
    dp.op(1, 4'h0, pcv | 32'h00000003);
    chk_w(pc_out, pcv | 32'h00000002);
    rdchk(4'h8, 1'b0, 32'h00000000);
    chk_b(illegal_access, 1'b1);
    rdchk(4'h8, 1'b1, mdl[8]);
    chk_b(illegal_access, 1'b0);
    rdchk(4'hD, 1'b0, mdl[slot(5'h13, 4'hD)]);
    // Narrow link offset, then the fast bank's own link
    dp.op(1, 4'h0, pcv | 32'h00000002);
    dp.op(2, 4'h0, 32'h00000000);
    rdchk(4'hE, 1'b0, (pcv | 32'h00000002) + 32'h00000002);
    set_mode(1);
    dp.op(1, 4'h0, pcv);
    dp.op(2, 4'h0, 32'h00000000);
    rdchk(4'hE, 1'b0, pcv + 32'h00000004);
    // Bad mode code, cleared again by a second reset
    dp.op(3, 4'h0, 32'h000000C5);
    chk_b(illegal_access, 1'b1);
    chk_b(privileged, 1'b0);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    chk_w(current_status_word, 32'h000000D3);
    rdchk(4'hE, 1'b0, 32'h00000000);
    tally_and_finish();
  end

  // Run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule : banked_mode_register_file_tb
